// [design/wlu_defs.svh]
// Constants for the word load instruction unit
`ifndef WLU_DEFS_SVH
`define WLU_DEFS_SVH
`define WLU_OP_X        6'h1f
`define WLU_OP_LOAD     6'h20
`define WLU_OP_LOADU    6'h21
`define WLU_XO_RESERVE  10'h014
`define WLU_XO_BREV     10'h216
`define WLU_XO_UPDX     10'h037
`define WLU_XO_INDEX    10'h017
`define WLU_EXC_NONE    2'h0
`define WLU_EXC_ALIGN   2'h1
`define WLU_EXC_DSI     2'h2
`define WLU_EXC_DTLB    2'h3
`endif

// [design/wlu_pkg.sv]
// Types for the word load instruction unit
package wlu_pkg;
   typedef enum logic [3:0] {
      WLU_IDLE = 4'h1,
      WLU_XLAT = 4'h2,
      WLU_MEM  = 4'h4,
      WLU_DONE = 4'h8
   } wlu_state_t;

   typedef enum logic [2:0] {
      WLU_F_NONE, WLU_F_RSV, WLU_F_BREV, WLU_F_DISP, WLU_F_DISPU, WLU_F_UPDX, WLU_F_IDX
   } wlu_form_t;

   typedef struct packed {
      wlu_form_t   form;
      logic        valid;
      logic        upd;
      logic [4:0]  tgt;
      logic [4:0]  base;
      logic [4:0]  index;
      logic [15:0] disp;
   } wlu_dec_t;
endpackage

// [design/wlu_dec_if.sv]
// Decoded instruction carrier between decoder and sequencer
`timescale 1ns/100ps
interface wlu_dec_if;
   logic [31:0]       instr;
   wlu_pkg::wlu_dec_t dec;
   modport decoder (input instr, output dec);
   modport user    (output instr, input dec);
endinterface

// [design/wlu_decode.sv]
// Instruction decoder for word loads
`timescale 1ns/100ps
`include "wlu_defs.svh"
module wlu_decode (
   // Decoded carrier
   wlu_dec_if.decoder d
);
   logic [5:0] opcd;
   logic [9:0] xo;
   // Big-endian fields: bit 0 is the msb
   assign opcd = d.instr[31:26];
   assign xo   = d.instr[10:1];

   // Classify; reserved bits ignored
   always_comb begin
      d.dec       = '0;
      d.dec.tgt   = d.instr[25:21];
      d.dec.base  = d.instr[20:16];
      d.dec.index = d.instr[15:11];
      d.dec.disp  = d.instr[15:0];
      d.dec.form  = wlu_pkg::WLU_F_NONE;
      if (opcd == `WLU_OP_LOAD) begin
         d.dec.form = wlu_pkg::WLU_F_DISP;
      end else if (opcd == `WLU_OP_LOADU) begin
         d.dec.form = wlu_pkg::WLU_F_DISPU;
      end else if (opcd == `WLU_OP_X) begin
         // Bit 31 not checked: nonzero reserved bits give bounded results
         unique case (xo)
            `WLU_XO_RESERVE: d.dec.form = wlu_pkg::WLU_F_RSV;
            `WLU_XO_BREV:    d.dec.form = wlu_pkg::WLU_F_BREV;
            `WLU_XO_UPDX:    d.dec.form = wlu_pkg::WLU_F_UPDX;
            `WLU_XO_INDEX:   d.dec.form = wlu_pkg::WLU_F_IDX;
            default:         d.dec.form = wlu_pkg::WLU_F_NONE;
         endcase
      end
      d.dec.valid = d.dec.form != wlu_pkg::WLU_F_NONE;
      d.dec.upd   = d.dec.form == wlu_pkg::WLU_F_DISPU || d.dec.form == wlu_pkg::WLU_F_UPDX;
   end
endmodule

// [design/wlu_align.sv]
// Byte lane assembly of a loaded word
`timescale 1ns/100ps
module wlu_align (
   // Memory word, byte at lowest address in [31:24]
   input  wire logic [31:0] mem_word,
   input  wire logic        reverse,
   // Register result
   output logic [31:0]      result
);
   // Big-endian normally, byte-reversed on request
   always_comb begin
      if (reverse) begin
         result = {mem_word[7:0], mem_word[15:8], mem_word[23:16], mem_word[31:24]};
      end else begin
         result = mem_word;
      end
   end
endmodule

// [design/wlu_core.sv]
// Word load instruction unit: decode, address, translate, load, write back
// How it works
// - Opcode 31 extended 20 loads a word and sets the reservation flag.
// - Reserve load with unaligned address raises alignment and skips the load.
// - Byte-reversed load, extended 534, puts address+3 byte in top target bits.
// - Opcode 32: base term plus sign-extended 16-bit displacement, load word.
// - Opcode 33 uses base register contents always, loads, writes address back.
// - Extended 55 adds base and index, loads, writes sum to base.
// - Extended 23 adds index to base term, loads, changes nothing else.
// - Non-update forms with base field 0 use constant zero as base.
// - Update forms with base zero or equal target raise no program exception.
// - Nonzero reserved bits give bounded results, never a program exception.
// - Relocated user access to no-access zone raises data storage exception.
// - Relocated access without valid translation raises data TLB miss.
`timescale 1ns/100ps
`include "wlu_defs.svh"
module wlu_core (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // Issue
   input  wire logic        issue_valid,
   input  wire logic [31:0] issue_instr,
   output logic             issue_ready,
   // Register file read (same clock, combinational read)
   output logic [4:0]       gpr_rd_a,
   output logic [4:0]       gpr_rd_b,
   input  wire logic [31:0] gpr_a_data,
   input  wire logic [31:0] gpr_b_data,
   // Register file write ports
   output logic             gpr_wr_en,
   output logic [4:0]       gpr_wr_idx,
   output logic [31:0]      gpr_wr_data,
   output logic             gpr_upd_en,
   output logic [4:0]       gpr_upd_idx,
   output logic [31:0]      gpr_upd_data,
   // Machine state
   input  wire logic        data_reloc,
   input  wire logic        user_mode,
   // Translation lookup
   output logic             tlb_req,
   output logic [31:0]      computed_addr,
   input  wire logic        tlb_hit,
   input  wire logic        zone_no_access,
   // Data memory
   output logic             mem_req,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   // Completion and exceptions
   output logic             done,
   output logic [1:0]       exc_code,
   output logic             reservation
);
   typedef struct packed {
      wlu_pkg::wlu_state_t st;
      wlu_pkg::wlu_dec_t   dec;
      logic [31:0]         addr;
      logic                ready;
      logic                tlb_req;
      logic                mem_req;
      logic                wr_en;
      logic [31:0]         wr_data;
      logic                upd_en;
      logic                done;
      logic [1:0]          exc;
      logic                rsv;
   } wlu_core_t;

   wlu_core_t s_reg;
   wlu_core_t s_next;
   wlu_dec_if dif ();
   logic [31:0] loaded;

   assign dif.instr = issue_instr;

   wlu_decode u_dec (
      .d (dif)
   );

   wlu_align u_align (
      .mem_word (mem_rdata),
      .reverse  (s_reg.dec.form == wlu_pkg::WLU_F_BREV),
      .result   (loaded)
   );

   // Sign extension of the displacement field
   function automatic logic [31:0] sext16(input logic [15:0] v);
      sext16 = {{16{v[15]}}, v};
   endfunction

   // Base term: zero for field 0 unless the form updates
   function automatic logic [31:0] base_term(input logic [4:0] f, input logic upd, input logic [31:0] v);
      base_term = (f == 5'h00 && !upd) ? 32'h0000_0000 : v;
   endfunction

   // Register reads follow the issuing instruction
   assign gpr_rd_a = dif.dec.base;
   assign gpr_rd_b = dif.dec.index;

   // Instruction accepted this cycle: only while ready, and only a word load
   logic taken;
   assign taken = issue_valid && s_reg.ready && dif.dec.valid;

   // Next-state logic
   always_comb begin
      logic [31:0] ea;
      logic        disp_form;
      ea        = 32'h0000_0000;
      disp_form = 1'b0;
      s_next         = s_reg;
      s_next.done    = 1'b0;
      s_next.wr_en   = 1'b0;
      s_next.upd_en  = 1'b0;
      s_next.tlb_req = 1'b0;
      unique case (s_reg.st)
         wlu_pkg::WLU_IDLE: begin
            s_next.ready = 1'b1;
            if (taken) begin
               disp_form = dif.dec.form == wlu_pkg::WLU_F_DISP || dif.dec.form == wlu_pkg::WLU_F_DISPU;
               // Base plus index or displacement; update forms never force zero
               ea = base_term(dif.dec.base, dif.dec.upd, gpr_a_data)
                  + (disp_form ? sext16(dif.dec.disp) : gpr_b_data);
               s_next.dec   = dif.dec;
               s_next.addr  = ea;
               s_next.ready = 1'b0;
               s_next.exc   = `WLU_EXC_NONE;
               // Base==target or base 0 on update: no program exception, result as computed
               if (dif.dec.form == wlu_pkg::WLU_F_RSV && ea[1:0] != 2'h0) begin
                  s_next.exc  = `WLU_EXC_ALIGN;
                  s_next.done = 1'b1;
                  s_next.st   = wlu_pkg::WLU_DONE;
               end else if (data_reloc) begin
                  s_next.tlb_req = 1'b1;
                  s_next.st      = wlu_pkg::WLU_XLAT;
               end else begin
                  s_next.mem_req = 1'b1;
                  s_next.st      = wlu_pkg::WLU_MEM;
               end
            end
         end
         wlu_pkg::WLU_XLAT: begin
            if (!tlb_hit) begin
               s_next.exc  = `WLU_EXC_DTLB;
               s_next.done = 1'b1;
               s_next.st   = wlu_pkg::WLU_DONE;
            end else if (user_mode && zone_no_access) begin
               s_next.exc  = `WLU_EXC_DSI;
               s_next.done = 1'b1;
               s_next.st   = wlu_pkg::WLU_DONE;
            end else begin
               s_next.mem_req = 1'b1;
               s_next.st      = wlu_pkg::WLU_MEM;
            end
         end
         wlu_pkg::WLU_MEM: begin
            if (mem_ack) begin
               s_next.mem_req = 1'b0;
               s_next.wr_en   = 1'b1;
               s_next.wr_data = loaded;
               s_next.upd_en  = s_reg.dec.upd;
               s_next.done    = 1'b1;
               if (s_reg.dec.form == wlu_pkg::WLU_F_RSV) begin
                  s_next.rsv = 1'b1;
               end
               s_next.st = wlu_pkg::WLU_DONE;
            end
         end
         wlu_pkg::WLU_DONE: begin
            s_next.ready = 1'b1;
            s_next.st    = wlu_pkg::WLU_IDLE;
         end
         default: begin
            s_next.st = wlu_pkg::WLU_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '{st: wlu_pkg::WLU_IDLE, dec: '0, addr: 32'h0, ready: 1'b0, tlb_req: 1'b0,
                    mem_req: 1'b0, wr_en: 1'b0, wr_data: 32'h0, upd_en: 1'b0, done: 1'b0,
                    exc: 2'h0, rsv: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign issue_ready   = s_reg.ready;
   assign tlb_req       = s_reg.tlb_req;
   assign computed_addr = s_reg.addr;
   assign mem_req       = s_reg.mem_req;
   assign gpr_wr_en     = s_reg.wr_en;
   assign gpr_wr_idx    = s_reg.dec.tgt;
   assign gpr_wr_data   = s_reg.wr_data;
   assign gpr_upd_en    = s_reg.upd_en;
   assign gpr_upd_idx   = s_reg.dec.base;
   assign gpr_upd_data  = s_reg.addr;
   assign done          = s_reg.done;
   assign exc_code      = s_reg.exc;
   assign reservation   = s_reg.rsv;

   // Alignment fault only for the reserve form, and never with a write
   align_fault_a: assert property (@(posedge clock) disable iff (!arst_n)
      done && exc_code == `WLU_EXC_ALIGN |-> s_reg.dec.form == wlu_pkg::WLU_F_RSV
      && computed_addr[1:0] != 2'h0 && !gpr_wr_en)
      else $error("alignment fault wrong");
   // Reserve load sets the flag on completion
   rsv_set_a: assert property (@(posedge clock) disable iff (!arst_n)
      gpr_wr_en && s_reg.dec.form == wlu_pkg::WLU_F_RSV |-> reservation)
      else $error("reservation not set");
   // Update write only alongside the target write of an update form
   upd_write_a: assert property (@(posedge clock) disable iff (!arst_n)
      gpr_upd_en |-> gpr_wr_en && s_reg.dec.upd)
      else $error("update without load");
   // Non-update forms write only the target
   no_upd_a: assert property (@(posedge clock) disable iff (!arst_n)
      gpr_wr_en && !s_reg.dec.upd |-> !gpr_upd_en)
      else $error("stray base write");
   // Byte reversal swaps lanes
   brev_data_a: assert property (@(posedge clock) disable iff (!arst_n)
      s_reg.st == wlu_pkg::WLU_MEM && mem_ack && s_reg.dec.form == wlu_pkg::WLU_F_BREV
      |=> gpr_wr_data[31:24] == $past(mem_rdata[7:0]))
      else $error("byte reverse wrong");
   // Big-endian lanes for normal loads
   be_data_a: assert property (@(posedge clock) disable iff (!arst_n)
      s_reg.st == wlu_pkg::WLU_MEM && mem_ack && s_reg.dec.form != wlu_pkg::WLU_F_BREV
      |=> gpr_wr_data == $past(mem_rdata))
      else $error("load data wrong");
   // Missing translation faults with no write
   tlb_miss_a: assert property (@(posedge clock) disable iff (!arst_n)
      s_reg.st == wlu_pkg::WLU_XLAT && !tlb_hit |=> exc_code == `WLU_EXC_DTLB && done && !gpr_wr_en)
      else $error("tlb miss lost");
   // Protected user access faults
   zone_fault_a: assert property (@(posedge clock) disable iff (!arst_n)
      s_reg.st == wlu_pkg::WLU_XLAT && tlb_hit && user_mode && zone_no_access
      |=> exc_code == `WLU_EXC_DSI && done)
      else $error("zone fault lost");
   // Zero base for field 0 on non-update indexed forms
   zero_base_a: assert property (@(posedge clock) disable iff (!arst_n)
      issue_valid && issue_ready && dif.dec.valid && !dif.dec.upd && dif.dec.base == 5'h00
      && dif.dec.form != wlu_pkg::WLU_F_DISP && dif.dec.form != wlu_pkg::WLU_F_DISPU
      |=> computed_addr == $past(gpr_b_data))
      else $error("zero base wrong");
   // Displacement load adds the sign-extended field to a nonzero base
   disp_addr_a: assert property (@(posedge clock) disable iff (!arst_n)
      taken && dif.dec.form == wlu_pkg::WLU_F_DISP && dif.dec.base != 5'h00
      |=> computed_addr == $past(gpr_a_data) + {{16{$past(issue_instr[15])}}, $past(issue_instr[15:0])})
      else $error("displacement address wrong");
   // Displacement load with base field 0 uses zero as base
   zero_disp_a: assert property (@(posedge clock) disable iff (!arst_n)
      taken && dif.dec.form == wlu_pkg::WLU_F_DISP && dif.dec.base == 5'h00
      |=> computed_addr == {{16{$past(issue_instr[15])}}, $past(issue_instr[15:0])})
      else $error("zero displacement base wrong");
   // Update by displacement always reads the base register
   dispu_addr_a: assert property (@(posedge clock) disable iff (!arst_n)
      taken && dif.dec.form == wlu_pkg::WLU_F_DISPU
      |=> computed_addr == $past(gpr_a_data) + {{16{$past(issue_instr[15])}}, $past(issue_instr[15:0])})
      else $error("update displacement address wrong");
   // Indexed update adds both registers
   updx_addr_a: assert property (@(posedge clock) disable iff (!arst_n)
      taken && dif.dec.form == wlu_pkg::WLU_F_UPDX |=> computed_addr == $past(gpr_a_data) + $past(gpr_b_data))
      else $error("indexed update address wrong");
   // Indexed forms with a nonzero base add both registers
   idx_addr_a: assert property (@(posedge clock) disable iff (!arst_n)
      taken && !dif.dec.upd && dif.dec.base != 5'h00 && dif.dec.form != wlu_pkg::WLU_F_DISP
      |=> computed_addr == $past(gpr_a_data) + $past(gpr_b_data))
      else $error("indexed address wrong");
   // Full byte reversal of the loaded word
   brev_word_a: assert property (@(posedge clock) disable iff (!arst_n)
      s_reg.st == wlu_pkg::WLU_MEM && mem_ack && s_reg.dec.form == wlu_pkg::WLU_F_BREV
      |=> gpr_wr_data == {$past(mem_rdata[7:0]), $past(mem_rdata[15:8]), $past(mem_rdata[23:16]),
      $past(mem_rdata[31:24])})
      else $error("reversed word wrong");
   // Relocated accesses look up a translation first
   reloc_lookup_a: assert property (@(posedge clock) disable iff (!arst_n)
      taken && data_reloc && dif.dec.form != wlu_pkg::WLU_F_RSV |=> tlb_req && !mem_req)
      else $error("lookup skipped");
   // Unrelocated accesses go straight to memory with no protection check
   plain_mem_a: assert property (@(posedge clock) disable iff (!arst_n)
      taken && !data_reloc && dif.dec.form != wlu_pkg::WLU_F_RSV |=> mem_req && !tlb_req)
      else $error("unrelocated access checked");
   // A fault writes no register and leaves memory alone
   fault_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
      done && exc_code != `WLU_EXC_NONE |-> !gpr_wr_en && !gpr_upd_en && !mem_req)
      else $error("fault with access");
   // Memory request holds until acknowledged
   mem_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      mem_req && !mem_ack |=> mem_req)
      else $error("memory request dropped");
   // Completion is one cycle, then the unit is ready again
   done_pulse_a: assert property (@(posedge clock) disable iff (!arst_n)
      done |-> !issue_ready ##1 (!done && issue_ready))
      else $error("completion timing wrong");
   // No new instruction while an access is open
   busy_ready_a: assert property (@(posedge clock) disable iff (!arst_n)
      tlb_req || mem_req |-> !issue_ready)
      else $error("ready while busy");
   // Reservation stays set once taken
   rsv_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
      reservation |=> reservation)
      else $error("reservation lost");

   rsv_load_c:  cover property (@(posedge clock) gpr_wr_en && reservation);
   upd_load_c:  cover property (@(posedge clock) gpr_upd_en);
   tlb_miss_c:  cover property (@(posedge clock) exc_code == `WLU_EXC_DTLB && done);
   align_c:     cover property (@(posedge clock) exc_code == `WLU_EXC_ALIGN && done);
   brev_load_c: cover property (@(posedge clock) gpr_wr_en && s_reg.dec.form == wlu_pkg::WLU_F_BREV);
endmodule

// [tb/wlu_mem_model.sv]
// Data memory and translation model facing the word load unit
`timescale 1ns/100ps
module wlu_mem_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // Scenario controls
   input  wire logic [1:0]  stall,
   input  wire logic        miss,
   input  wire logic        zone,
   // Translation side
   input  wire logic        tlb_req,
   output logic             tlb_hit,
   output logic             zone_no_access,
   // Memory side
   input  wire logic [31:0] computed_addr,
   input  wire logic        mem_req,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [1:0] wait_reg;
   // Lookup answer stands while the request is high; inverted otherwise so stale levels are caught
   assign tlb_hit        = tlb_req ? !miss : miss;
   assign zone_no_access = tlb_req ? zone : !zone;
   // Acknowledge after the stall count; read data changes every cycle outside the acknowledge
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wait_reg  <= 2'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h0;
      end else if (mem_req && !mem_ack && wait_reg == stall) begin
         wait_reg  <= 2'h0;
         mem_ack   <= 1'b1;
         mem_rdata <= computed_addr ^ 32'h5a3c96e1;
      end else begin
         wait_reg  <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// [tb/word_load_instruction_unit_test.sv]
// Self-checking bench for the word load instruction unit
`timescale 1ns/100ps
`include "wlu_defs.svh"
module word_load_instruction_unit_test;
   logic        clock, arst_n, issue_valid, issue_ready, data_reloc, user_mode, miss, zone, saw_req, saw_tlb;
   logic        gpr_wr_en, gpr_upd_en, tlb_req, tlb_hit, zone_no_access, mem_req, mem_ack, done, reservation;
   logic [31:0] issue_instr, gpr_a_data, gpr_b_data, gpr_wr_data, gpr_upd_data, computed_addr, mem_rdata, seed;
   logic [4:0]  gpr_rd_a, gpr_rd_b, gpr_wr_idx, gpr_upd_idx;
   logic [1:0]  exc_code, stall;
   logic [31:0] gpr [32];
   int          err_total, comparisons;
   // Clock and register file read
   initial clock = 1'b0;
   always #2.5 clock = ~clock;
   assign gpr_a_data = gpr[gpr_rd_a];
   assign gpr_b_data = gpr[gpr_rd_b];
   // Note any memory or translation request during an operation
   always @(posedge clock) if (mem_req === 1'b1) saw_req = 1'b1;
   always @(posedge clock) if (tlb_req === 1'b1) saw_tlb = 1'b1;
   wlu_core dut_u (.clock, .arst_n, .issue_valid, .issue_instr, .issue_ready, .gpr_rd_a, .gpr_rd_b,
      .gpr_a_data, .gpr_b_data, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data, .gpr_upd_en, .gpr_upd_idx,
      .gpr_upd_data, .data_reloc, .user_mode, .tlb_req, .computed_addr, .tlb_hit, .zone_no_access,
      .mem_req, .mem_ack, .mem_rdata, .done, .exc_code, .reservation);
   wlu_mem_model mem_u (.clock, .arst_n, .stall, .miss, .zone, .tlb_req, .tlb_hit, .zone_no_access,
      .computed_addr, .mem_req, .mem_ack, .mem_rdata);
   // Repeatable xorshift source
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Instruction word for form 0..5: reserve, reversed, disp, disp update, indexed update, indexed
   function automatic logic [31:0] mk(int f, logic [4:0] rt, logic [4:0] ra, logic [4:0] rb, logic [15:0] d);
      logic [9:0] xo;
      xo = (f == 0) ? `WLU_XO_RESERVE : (f == 1) ? `WLU_XO_BREV : (f == 4) ? `WLU_XO_UPDX : `WLU_XO_INDEX;
      if (f == 2) return {`WLU_OP_LOAD, rt, ra, d};
      if (f == 3) return {`WLU_OP_LOADU, rt, ra, d};
      return {`WLU_OP_X, rt, ra, rb, xo, 1'b0};
   endfunction
   function automatic logic is_x(logic [31:0] ins, logic [9:0] xo);
      return ins[31:26] == `WLU_OP_X && ins[10:1] == xo;
   endfunction
   function automatic logic is_upd(logic [31:0] ins);
      return ins[31:26] == `WLU_OP_LOADU || is_x(ins, `WLU_XO_UPDX);
   endfunction
   // Expected address: base term plus index or sign-extended displacement
   function automatic logic [31:0] exp_addr(logic [31:0] ins);
      logic [31:0] base;
      logic [31:0] off;
      base = (ins[20:16] == 5'h00 && !is_upd(ins)) ? 32'h0 : gpr[ins[20:16]];
      off  = (ins[31:26] == `WLU_OP_X) ? gpr[ins[15:11]] : {{16{ins[15]}}, ins[15:0]};
      return base + off;
   endfunction
   task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One load; c holds reloc, user, miss, zone, stall[1:0]
   task automatic run(logic [31:0] ins, logic [5:0] c);
      logic [31:0] ea, word;
      logic [1:0]  exc;
      int          n;
      ea   = exp_addr(ins);
      word = ea ^ 32'h5a3c96e1;
      exc  = (is_x(ins, `WLU_XO_RESERVE) && ea[1:0] != 2'h0) ? `WLU_EXC_ALIGN :
             (c[0] && c[2]) ? `WLU_EXC_DTLB : (c[0] && c[1] && c[3]) ? `WLU_EXC_DSI : `WLU_EXC_NONE;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (issue_ready !== 1'b1 && n < 20);
      if (issue_ready !== 1'b1) begin
         err_total++;
         $display("MISMATCH at %0t: never ready", $time);
         wrap_up();
      end
      @(posedge clock);
      {stall, zone, miss, user_mode, data_reloc} <= c;
      issue_valid <= 1'b1;
      issue_instr <= ins;
      saw_req = 1'b0;
      saw_tlb = 1'b0;
      @(posedge clock);
      issue_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (done !== 1'b1 && n < 20);
      if (done !== 1'b1) begin
         err_total++;
         $display("MISMATCH at %0t: no completion", $time);
         wrap_up();
      end
      check(exc_code, exc, "exception code");
      check(saw_req, exc == `WLU_EXC_NONE, "memory access");
      check(saw_tlb, c[0] && exc != `WLU_EXC_ALIGN, "translation lookup");
      check(computed_addr, ea, "address");
      check(gpr_wr_en, exc == `WLU_EXC_NONE, "target write");
      check(gpr_upd_en, exc == `WLU_EXC_NONE && is_upd(ins), "base write");
      if (exc == `WLU_EXC_NONE) begin
         check(gpr_wr_idx, ins[25:21], "target index");
         check(gpr_wr_data, is_x(ins, `WLU_XO_BREV) ? {<<8{word}} : word, "load data");
      end
      if (exc == `WLU_EXC_NONE && is_upd(ins)) begin
         check(gpr_upd_idx, ins[20:16], "base index");
         check(gpr_upd_data, ea, "base value");
      end
   endtask
   // Main sequence: reset, corners, ignored opcodes, random traffic
   initial begin
      logic [31:0] r, q;
      int          f;
      seed = 32'h54;
      {arst_n, issue_valid, issue_instr, data_reloc, user_mode, miss, zone, stall, saw_req, saw_tlb} = '0;
      err_total = 0;
      comparisons = 0;
      foreach (gpr[i]) gpr[i] = xs();
      gpr[1] = 32'h00001000;
      gpr[2] = 32'h00000002;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      check(reservation, 1'b0, "reservation after reset");
      run(mk(2, 5'h03, 5'h00, 5'h00, 16'h8000), 6'h00);
      run(mk(5, 5'h04, 5'h00, 5'h01, 16'h0000), 6'h30);
      run(mk(0, 5'h05, 5'h01, 5'h02, 16'h0000), 6'h00);
      run(mk(5, 5'h06, 5'h01, 5'h02, 16'h0000) | 32'h1, 6'h10);
      run(mk(2, 5'h07, 5'h01, 5'h00, 16'h0004), 6'h0f);
      run(mk(2, 5'h07, 5'h01, 5'h00, 16'h0004), 6'h0b);
      run(mk(2, 5'h07, 5'h01, 5'h00, 16'h0004), 6'h09);
      run(mk(1, 5'h08, 5'h01, 5'h02, 16'h0000), 6'h21);
      run(mk(3, 5'h03, 5'h01, 5'h00, 16'hfffc), 6'h10);
      run(mk(4, 5'h04, 5'h01, 5'h02, 16'h0000), 6'h01);
      check(reservation, 1'b0, "reservation before reserve load");
      run(mk(0, 5'h09, 5'h00, 5'h01, 16'h0000), 6'h00);
      check(reservation, 1'b1, "reservation after reserve load");
      // Foreign opcodes are not taken and give no completion
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         issue_instr <= (k == 0) ? 32'h88200000 : {`WLU_OP_X, 10'h000, 5'h01, 10'h215, 1'b0};
         issue_valid <= 1'b1;
         @(posedge clock);
         issue_valid <= 1'b0;
         repeat (8) @(negedge clock) check(done, 1'b0, "foreign opcode");
      end
      for (int k = 0; k < 60; k++) begin
         r = xs();
         q = xs();
         f = r[2:0] % 6;
         if (f == 3 || f == 4) r[9:5] = r[9:5] | 5'h01;
         if (f == 3 || f == 4) r[4:0] = r[9:5] ^ 5'h02;
         run(mk(f, r[4:0], r[9:5], r[14:10], r[31:16]), {q[5:4], q[3], q[2] & q[6], q[1:0]});
      end
      wrap_up();
   end
endmodule
